// file: rtl/cssc_pkg.sv
package cssc_pkg;
  localparam int REF_CLK_KHZ = 100000;
  localparam int STEP_US = 250;
  localparam int STEP_CYC = REF_CLK_KHZ * STEP_US / 1000;
  localparam int FALL_MIN_US = 500;
  localparam int FALL_MIN_CYC = REF_CLK_KHZ * FALL_MIN_US / 1000;
  localparam int PIN_DET_US = 8000;
  localparam int PIN_DET_CYC = REF_CLK_KHZ / 1000 * PIN_DET_US;
  localparam int AUTO_WIN_US = 20;
  localparam int AUTO_WIN_CYC = REF_CLK_KHZ / 1000 * AUTO_WIN_US;
  localparam int SLOW_NUM = 10;
  localparam int SLOW_DEN = 7;
  localparam int REF_BITS = 10;
  localparam int RAMP_BITS = 23;
  localparam int FREQ_COUNT = 12;

  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ON_OFF = 8'h02;
  localparam logic [7:0] CMD_FREQ = 8'h33;
  localparam logic [7:0] CMD_OV_WARN = 8'h42;
  localparam logic [7:0] CMD_UV_WARN = 8'h43;
  localparam logic [7:0] CMD_TON_RISE = 8'h61;
  localparam logic [7:0] CMD_TOFF_FALL = 8'h65;
  localparam logic [7:0] CMD_STATUS = 8'hE0;
  localparam logic [7:0] CMD_STRAPS = 8'hE1;
  localparam logic [7:0] CMD_MISC = 8'hE2;

  localparam int OP_ON_BIT = 7;
  localparam int OP_SOFT_BIT = 6;
  localparam int ONOFF_SOFT_BIT = 0;
  localparam int ONOFF_PIN_BIT = 1;
  localparam int MISC_PG_FAULT_BIT = 0;

  localparam logic [7:0] OPERATION_RST = 8'h80;
  localparam logic [7:0] ON_OFF_RST = 8'h02;
  localparam logic [6:0] TON_RISE_RST = 7'h0C;
  localparam logic [6:0] TOFF_FALL_RST = 7'h00;
  localparam logic [15:0] OV_WARN_RST = 16'hFFFF;
  localparam logic [15:0] UV_WARN_RST = 16'h0000;
  localparam logic MISC_PG_FAULT_RST = 1'b1;

  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_RISE = 4'h2,
    ST_ON = 4'h4,
    ST_FALL = 4'h8
  } cssc_state_type;

  // switching period in reference clock cycles for frequency index
  function automatic logic [11:0] fsw_period(input logic [3:0] idx);
    unique case (idx)
      4'h0: fsw_period = 12'(REF_CLK_KHZ / 225);
      4'h1: fsw_period = 12'(REF_CLK_KHZ / 275);
      4'h2: fsw_period = 12'(REF_CLK_KHZ / 325);
      4'h3: fsw_period = 12'(REF_CLK_KHZ / 375);
      4'h4: fsw_period = 12'(REF_CLK_KHZ / 450);
      4'h5: fsw_period = 12'(REF_CLK_KHZ / 550);
      4'h6: fsw_period = 12'(REF_CLK_KHZ / 650);
      4'h7: fsw_period = 12'(REF_CLK_KHZ / 750);
      4'h8: fsw_period = 12'(REF_CLK_KHZ / 900);
      4'h9: fsw_period = 12'(REF_CLK_KHZ / 1100);
      4'hA: fsw_period = 12'(REF_CLK_KHZ / 1300);
      default: fsw_period = 12'(REF_CLK_KHZ / 1500);
    endcase
  endfunction : fsw_period

  // frequency strap code to frequency index
  function automatic logic [3:0] strap_freq_idx(input logic [2:0] code);
    unique case (code)
      3'h0: strap_freq_idx = 4'h1;
      3'h1: strap_freq_idx = 4'h2;
      3'h2: strap_freq_idx = 4'h4;
      3'h3: strap_freq_idx = 4'h5;
      3'h4: strap_freq_idx = 4'h6;
      3'h5: strap_freq_idx = 4'h8;
      3'h6: strap_freq_idx = 4'h9;
      default: strap_freq_idx = 4'hB;
    endcase
  endfunction : strap_freq_idx
endpackage : cssc_pkg

// file: rtl/cssc_top.sv
`timescale 1ns/1ps
module cssc_top
  import cssc_pkg::*;
#(
  parameter int PIN_DET_CYCLES = PIN_DET_CYC
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic en_pin_i,
  input wire logic sync_pin_i,
  output logic sync_out_o,
  output logic sync_oe_n_o,
  input wire logic [2:0] frequency_strap_pin_i,
  input wire logic [3:0] stack_strap_pin_i,
  input wire logic [3:0] address_phase_strap_pin_i,
  input wire logic address_phase_strap_open_i,
  input wire logic ground_sense_follower_pin_i,
  input wire logic [15:0] vout_code_i,
  input wire logic fault_shutdown_i,
  output logic power_good_output_o,
  output logic power_good_output_oe_n_o,
  output logic hs_drv_en_o,
  output logic ls_drv_en_o,
  output logic neg_current_en_o,
  output logic [REF_BITS-1:0] ref_level_o,
  output logic pwm_clk_o,
  output logic sync_lost_o
);

  localparam int PW = 15;
  localparam logic [REF_BITS-1:0] REF_FULL = '1;
  localparam logic [RAMP_BITS-1:0] REF_STEPS = RAMP_BITS'(1 << REF_BITS);

  // pin synchronisers, three stages
  logic [PW-1:0] pin_raw, pin_s1, pin_s2, pin_s3, pin_f;
  assign pin_raw = {en_pin_i, sync_pin_i, ground_sense_follower_pin_i,
                    address_phase_strap_open_i, address_phase_strap_pin_i,
                    stack_strap_pin_i, frequency_strap_pin_i};

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      pin_f <= '0;
    end else begin
      for (int i = 0; i < PW; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_f[i] <= pin_s3[i];
        end
      end
    end
  end

  logic en_f, sync_f, sync_d, sync_edge;
  assign en_f = pin_f[14];
  assign sync_f = pin_f[13];
  assign sync_edge = sync_f & ~sync_d;

  // power-on pin detection delay
  logic [31:0] det_cnt;
  logic por_done, det_pulse;
  assign det_pulse = !por_done && (det_cnt == 32'(PIN_DET_CYCLES));

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      det_cnt <= '0;
      por_done <= 1'b0;
    end else if (!por_done) begin
      det_cnt <= det_cnt + 32'h1;
      if (det_pulse) begin
        por_done <= 1'b1;
      end
    end
  end

  // strap decode, latched once
  logic follower, adr_auto, adr_out, stacked;
  logic [2:0] adr_phase, stk_phase, phase_code;
  logic [1:0] stk_cnt_m1, stk_pos;

  function automatic logic [2:0] stack_phase(input logic [1:0] cm1,
                                             input logic [1:0] pos);
    unique case (cm1)
      2'h0: stack_phase = 3'h0;
      2'h1: stack_phase = pos[0] ? 3'h3 : 3'h0;
      2'h2: stack_phase = (pos == 2'h1) ? 3'h2 : (pos == 2'h2) ? 3'h4 : 3'h0;
      default: stack_phase = (pos == 2'h1) ? 3'h1 : (pos == 2'h2) ? 3'h3 :
                             (pos == 2'h3) ? 3'h5 : 3'h0;
    endcase
  endfunction : stack_phase

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      follower <= 1'b0;
      adr_auto <= 1'b0;
      adr_out <= 1'b0;
      adr_phase <= 3'h0;
      stk_cnt_m1 <= 2'h0;
      stk_pos <= 2'h0;
    end else if (det_pulse) begin
      follower <= pin_f[12];
      adr_auto <= pin_f[11];
      adr_out <= !pin_f[11] && (pin_f[10:9] == 2'h3);
      if (pin_f[11]) begin
        adr_phase <= 3'h0;
      end else if (pin_f[10:8] == 3'h6) begin
        adr_phase <= 3'h0;
      end else if (pin_f[10:8] == 3'h7) begin
        adr_phase <= 3'h3;
      end else begin
        adr_phase <= pin_f[10:8];
      end
      stk_cnt_m1 <= pin_f[4:3];
      stk_pos <= pin_f[6:5];
    end
  end

  assign stacked = follower || (stk_cnt_m1 != 2'h0);
  assign stk_phase = stack_phase(stk_cnt_m1, stk_pos);
  assign phase_code = stacked ? stk_phase : adr_phase;

  // registers
  logic [7:0] op, onoff;
  logic [3:0] freq_idx;
  logic [15:0] ov_lim, uv_lim;
  logic [6:0] ton, toff;
  logic pg_fault_en;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      op <= OPERATION_RST;
      onoff <= ON_OFF_RST;
      ov_lim <= OV_WARN_RST;
      uv_lim <= UV_WARN_RST;
      ton <= TON_RISE_RST;
      toff <= TOFF_FALL_RST;
      pg_fault_en <= MISC_PG_FAULT_RST;
    end else if (wr_i) begin
      unique case (addr_i)
        CMD_OPERATION: op <= wdata_i[7:0];
        CMD_ON_OFF: onoff <= wdata_i[7:0];
        CMD_OV_WARN: ov_lim <= wdata_i;
        CMD_UV_WARN: uv_lim <= wdata_i;
        CMD_TON_RISE: ton <= wdata_i[6:0];
        CMD_TOFF_FALL: toff <= wdata_i[6:0];
        CMD_MISC: pg_fault_en <= wdata_i[MISC_PG_FAULT_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      freq_idx <= 4'h0;
    end else if (det_pulse) begin
      freq_idx <= strap_freq_idx(pin_f[2:0]);
    end else if (wr_i && addr_i == CMD_FREQ &&
                 wdata_i < 16'(FREQ_COUNT)) begin
      freq_idx <= wdata_i[3:0];
    end
  end

  // sync role resolution
  logic role_done, role_in;
  logic [15:0] win_cnt;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      role_done <= 1'b0;
      role_in <= 1'b0;
      win_cnt <= '0;
    end else if (por_done && !role_done) begin
      if (follower) begin
        role_in <= 1'b1;
        role_done <= 1'b1;
      end else if (!adr_auto) begin
        role_in <= !adr_out;
        role_done <= 1'b1;
      end else if (sync_f || sync_edge) begin
        role_in <= 1'b1;
        role_done <= 1'b1;
      end else if (win_cnt == 16'(AUTO_WIN_CYC)) begin
        role_in <= 1'b0;
        role_done <= 1'b1;
      end else begin
        win_cnt <= win_cnt + 16'h1;
      end
    end
  end

  // oscillator
  logic [11:0] per, per_eff, osc_cnt, offset;
  logic [12:0] per_slow;
  logic osc_wrap, locking, lost;
  logic [1:0] miss;
  logic [12:0] gap;

  function automatic logic [11:0] phase_offset(input logic [11:0] p,
                                               input logic [2:0] c);
    unique case (c)
      3'h0: phase_offset = 12'h0;
      3'h1: phase_offset = p >> 2;
      3'h2: phase_offset = 12'(p / 12'h3);
      3'h3: phase_offset = p >> 1;
      3'h4: phase_offset = 12'((13'(p) << 1) / 13'h3);
      default: phase_offset = 12'((13'(p) * 13'h3) >> 2);
    endcase
  endfunction : phase_offset

  assign per = fsw_period(freq_idx);
  assign per_slow = 13'((13'(per) * 13'(SLOW_NUM)) / 13'(SLOW_DEN));
  assign per_eff = (lost && !stacked) ? per_slow[11:0] : per;
  assign offset = phase_offset(per_eff, phase_code);
  assign locking = role_done && role_in;
  assign osc_wrap = osc_cnt >= per_eff - 12'h1;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      sync_d <= 1'b0;
    end else begin
      sync_d <= sync_f;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      osc_cnt <= '0;
    end else if (locking && sync_edge) begin
      osc_cnt <= (offset == 12'h0) ? 12'h0 : per_eff - offset;
    end else if (osc_wrap) begin
      osc_cnt <= '0;
    end else begin
      osc_cnt <= osc_cnt + 12'h1;
    end
  end

  // sync loss detection
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      miss <= 2'h0;
      gap <= '0;
      lost <= 1'b0;
    end else if (!locking || sync_edge) begin
      miss <= 2'h0;
      gap <= '0;
      lost <= 1'b0;
    end else begin
      if (osc_wrap && miss != 2'h2) begin
        miss <= miss + 2'h1;
      end
      if (gap != '1) begin
        gap <= gap + 13'h1;
      end
      if (miss == 2'h2 || gap > {per, 1'b0}) begin
        lost <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      pwm_clk_o <= 1'b0;
      sync_out_o <= 1'b0;
      sync_oe_n_o <= 1'b1;
      sync_lost_o <= 1'b0;
    end else begin
      pwm_clk_o <= osc_cnt < (per_eff >> 1);
      sync_out_o <= osc_cnt < (per_eff >> 1);
      sync_oe_n_o <= !(role_done && !role_in);
      sync_lost_o <= lost;
    end
  end

  // conversion state machine
  cssc_state_type state;
  logic [REF_BITS-1:0] level;
  logic [RAMP_BITS-1:0] err, err_n, rise_tot, fall_tot;
  logic pin_ok, conv_req, hard_off, soft_sel, ramp_step;

  assign pin_ok = !onoff[ONOFF_PIN_BIT] || en_f;
  assign hard_off = fault_shutdown_i || (stacked && lost);
  assign conv_req = por_done && op[OP_ON_BIT] && pin_ok && !hard_off;
  assign soft_sel = !op[OP_ON_BIT] ? op[OP_SOFT_BIT]
                                   : onoff[ONOFF_SOFT_BIT];
  assign rise_tot = RAMP_BITS'(ton) * RAMP_BITS'(STEP_CYC);
  assign fall_tot = (toff == 7'h0) ? RAMP_BITS'(FALL_MIN_CYC)
                    : RAMP_BITS'(toff) * RAMP_BITS'(STEP_CYC);
  assign err_n = err + REF_STEPS;
  assign ramp_step = err_n >= ((state == ST_FALL) ? fall_tot : rise_tot);

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state <= ST_OFF;
      level <= '0;
      err <= '0;
    end else begin
      unique case (state)
        ST_OFF: begin
          level <= '0;
          err <= '0;
          if (conv_req) begin
            if (ton == 7'h0) begin
              level <= REF_FULL;
              state <= ST_ON;
            end else begin
              state <= ST_RISE;
            end
          end
        end
        ST_RISE, ST_ON: begin
          if (!conv_req) begin
            err <= '0;
            if (hard_off || !soft_sel) begin
              state <= ST_OFF;
            end else begin
              state <= ST_FALL;
            end
          end else if (state == ST_RISE) begin
            err <= ramp_step ? err_n - rise_tot : err_n;
            if (ramp_step) begin
              level <= level + REF_BITS'(1);
              if (level == REF_FULL - REF_BITS'(1)) begin
                state <= ST_ON;
              end
            end
          end
        end
        ST_FALL: begin
          if (hard_off) begin
            state <= ST_OFF;
          end else begin
            err <= ramp_step ? err_n - fall_tot : err_n;
            if (ramp_step) begin
              level <= level - REF_BITS'(1);
              if (level == REF_BITS'(1)) begin
                state <= ST_OFF;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      hs_drv_en_o <= 1'b0;
      ls_drv_en_o <= 1'b0;
      neg_current_en_o <= 1'b0;
      ref_level_o <= '0;
    end else begin
      hs_drv_en_o <= state != ST_OFF;
      ls_drv_en_o <= state != ST_OFF;
      neg_current_en_o <= state == ST_FALL;
      ref_level_o <= level;
    end
  end

  // power good
  logic pg_ok;
  assign pg_ok = (state == ST_ON) && conv_req &&
                 vout_code_i >= uv_lim && vout_code_i <= ov_lim &&
                 !(fault_shutdown_i && pg_fault_en);

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      power_good_output_o <= 1'b0;
      power_good_output_oe_n_o <= 1'b0;
    end else begin
      power_good_output_o <= 1'b0;
      power_good_output_oe_n_o <= pg_ok;
    end
  end

  // register read port
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      unique case (addr_i)
        CMD_OPERATION: rdata_o <= {8'h00, op};
        CMD_ON_OFF: rdata_o <= {8'h00, onoff};
        CMD_FREQ: rdata_o <= {12'h000, freq_idx};
        CMD_OV_WARN: rdata_o <= ov_lim;
        CMD_UV_WARN: rdata_o <= uv_lim;
        CMD_TON_RISE: rdata_o <= {9'h000, ton};
        CMD_TOFF_FALL: rdata_o <= {9'h000, toff};
        CMD_STATUS: rdata_o <= {5'h00, pg_ok, lost, role_in, role_done,
                                por_done, follower, stacked, state};
        CMD_STRAPS: rdata_o <= {4'h0, adr_auto, adr_out, adr_phase,
                                stk_pos, stk_cnt_m1, phase_code};
        CMD_MISC: rdata_o <= {15'h0000, pg_fault_en};
        default: rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

endmodule : cssc_top

// file: testbench/cssc_sync_src.sv
`timescale 1ns/1ps
module cssc_sync_src (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [11:0] per_i,
  output logic sync_o
);
  logic [11:0] cnt;

  // a stopped source sits steady low, a running one is high for the first half of each period
  always_ff @(posedge clk_i) begin
    if (!run_i) begin
      cnt <= 12'h000;
      sync_o <= 1'b0;
    end else begin
      cnt <= (cnt >= per_i - 12'h001) ? 12'h000 : cnt + 12'h001;
      sync_o <= (cnt < (per_i >> 1));
    end
  end
endmodule : cssc_sync_src

// file: testbench/cssc_top_properties.sv
`timescale 1ns/1ps
module cssc_top_properties
  import cssc_pkg::*;
#(
  parameter int PIN_DET_CYCLES = PIN_DET_CYC
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic fault_shutdown_i,
  input wire logic sync_oe_n_o,
  input wire logic sync_lost_o,
  input wire logic power_good_output_oe_n_o,
  input wire logic hs_drv_en_o,
  input wire logic ls_drv_en_o,
  input wire logic neg_current_en_o,
  input wire logic [REF_BITS-1:0] ref_level_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  int unsigned up_cnt;

  // counts the pin detection span after each release of reset
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      up_cnt <= 0;
    end else if (up_cnt < PIN_DET_CYCLES) begin
      up_cnt <= up_cnt + 1;
    end
  end

  sequence drv_off_s;
    !hs_drv_en_o && !ls_drv_en_o && !neg_current_en_o;
  endsequence
  sequence fault_held_s;
    fault_shutdown_i ##1 fault_shutdown_i;
  endsequence

  AST_PG_NEEDS_DRV: assert property (
    power_good_output_oe_n_o |-> hs_drv_en_o && ls_drv_en_o)
    else $error("power good released with drivers off");
  AST_PG_NO_FALL: assert property (
    neg_current_en_o |-> !power_good_output_oe_n_o)
    else $error("power good released during soft stop");
  AST_FAULT_PG: assert property (
    fault_shutdown_i |=> !power_good_output_oe_n_o)
    else $error("power good not pulled low on fault");
  AST_FAULT_OFF: assert property (
    fault_held_s |-> ##[0:2] drv_off_s)
    else $error("drivers not off after fault");
  AST_HS_LS_PAIR: assert property (
    hs_drv_en_o == ls_drv_en_o)
    else $error("drivers switched apart");
  AST_NEG_ON_DRV: assert property (
    neg_current_en_o |-> hs_drv_en_o && ls_drv_en_o)
    else $error("negative current without drivers");
  AST_FALL_DOWN: assert property (
    neg_current_en_o |=> ref_level_o <= $past(ref_level_o))
    else $error("reference rose during soft stop");
  AST_OUT_NOT_LOST: assert property (
    !sync_oe_n_o |-> !sync_lost_o)
    else $error("sync lost flagged in output role");
  AST_NO_CONV_EARLY: assert property (
    up_cnt < PIN_DET_CYCLES |-> !hs_drv_en_o)
    else $error("conversion before pin detection");
endmodule : cssc_top_properties

bind cssc_top cssc_top_properties #(.PIN_DET_CYCLES(PIN_DET_CYCLES))
  u_cssc_top_properties (.ref_clk_i, .nrst_i, .fault_shutdown_i,
  .sync_oe_n_o, .sync_lost_o, .power_good_output_oe_n_o, .hs_drv_en_o,
  .ls_drv_en_o, .neg_current_en_o, .ref_level_o);

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import cssc_pkg::*;
  logic ref_clk_i, nrst_i, wr_i, rd_i, en_pin_i, sync_pin_i;
  logic [7:0] addr_i;
  logic [15:0] wdata_i, rdata_o, vout_code_i;
  logic sync_out_o, sync_oe_n_o, address_phase_strap_open_i;
  logic ground_sense_follower_pin_i, fault_shutdown_i, sync_lost_o;
  logic power_good_output_o, power_good_output_oe_n_o, hs_drv_en_o;
  logic ls_drv_en_o, neg_current_en_o, pwm_clk_o, src_run, src_sync;
  logic [2:0] frequency_strap_pin_i;
  logic [3:0] stack_strap_pin_i, address_phase_strap_pin_i;
  logic [REF_BITS-1:0] ref_level_o;
  int n_errors, compares;
  int khz [12] = '{225, 275, 325, 375, 450, 550, 650, 750, 900, 1100,
    1300, 1500};

  cssc_top #(.PIN_DET_CYCLES(20)) u_cssc_top (.ref_clk_i, .nrst_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .en_pin_i, .sync_pin_i,
    .sync_out_o, .sync_oe_n_o, .frequency_strap_pin_i, .stack_strap_pin_i,
    .address_phase_strap_pin_i, .address_phase_strap_open_i,
    .ground_sense_follower_pin_i, .vout_code_i, .fault_shutdown_i,
    .power_good_output_o, .power_good_output_oe_n_o, .hs_drv_en_o,
    .ls_drv_en_o, .neg_current_en_o, .ref_level_o, .pwm_clk_o,
    .sync_lost_o);
  cssc_sync_src u_cssc_sync_src (.clk_i(ref_clk_i), .run_i(src_run),
    .per_i(12'hB5), .sync_o(src_sync));
  // the sync wire follows whoever drives it
  assign sync_pin_i = sync_oe_n_o ? src_sync : sync_out_o;

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    repeat (100000) @(posedge ref_clk_i);
    n_errors = n_errors + 1;
    results();
  end

  task automatic results();
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  task automatic check(input string nm, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    d = rdata_o;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    check($sformatf("reg %h", a), d, e);
  endtask : rdc

  task automatic waitv(input string nm, ref logic s, input logic v,
    input int maxc, output int n);
    n = 0;
    while (s !== v && n < maxc) begin
      @(negedge ref_clk_i);
      n++;
    end
    check(nm, 16'(s), 16'(v));
  endtask : waitv

  task automatic per_of(output int p);
    int a, b;
    // the first rise after a period change may be cut short, skip it
    waitv("pwm", pwm_clk_o, 1'b0, 1000, a);
    waitv("pwm", pwm_clk_o, 1'b1, 1000, a);
    waitv("pwm", pwm_clk_o, 1'b0, 1000, a);
    waitv("pwm", pwm_clk_o, 1'b1, 1000, a);
    waitv("pwm", pwm_clk_o, 1'b0, 1000, a);
    waitv("pwm", pwm_clk_o, 1'b1, 1000, b);
    p = a + b;
  endtask : per_of

  task automatic do_reset();
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
  endtask : do_reset

  task automatic t_regs();
    check("pg", 16'(power_good_output_oe_n_o), 16'h0000);
    check("pg drive", 16'(power_good_output_o), 16'h0000);
    rdc(8'h01, 16'h0080);
    rdc(8'h02, 16'h0002);
    rdc(8'h61, 16'h000C);
    rdc(8'h65, 16'h0000);
    rdc(8'h42, 16'hFFFF);
    rdc(8'h43, 16'h0000);
    rdc(8'hE2, 16'h0001);
    rdc(8'h10, 16'h0000);
    wr(8'h61, 16'h00FF);
    rdc(8'h61, 16'h007F);
  endtask : t_regs

  task automatic t_auto_out();
    int n, p;
    logic [15:0] d;
    repeat (25) @(negedge ref_clk_i);
    check("oe early", 16'(sync_oe_n_o), 16'h0001);
    waitv("sync oe", sync_oe_n_o, 1'b0, 2200, n);
    waitv("sync out", sync_out_o, 1'b1, 500, n);
    waitv("sync out", sync_out_o, 1'b0, 500, n);
    rdc(8'h33, 16'h0005);
    rd(8'hE1, d);
    check("auto", 16'(d[11]), 16'h0001);
    check("phase", 16'(d[2:0]), 16'h0000);
    for (int i = 0; i < FREQ_COUNT; i++) begin
      wr(8'h33, 16'(i));
      per_of(p);
      check("period", 16'(p), 16'(REF_CLK_KHZ / khz[i]));
    end
    wr(8'h33, 16'h000C);
    rdc(8'h33, 16'h000B);
  endtask : t_auto_out

  task automatic t_auto_in();
    int n, p;
    logic [15:0] d;
    @(posedge ref_clk_i);
    src_run <= 1'b1;
    do_reset();
    repeat (2100) @(negedge ref_clk_i);
    rd(8'hE0, d);
    check("role in", 16'(d[8]), 16'h0001);
    check("lost", 16'(d[9]), 16'h0000);
    check("oe in", 16'(sync_oe_n_o), 16'h0001);
    per_of(p);
    check("sync period", 16'(p), 16'(REF_CLK_KHZ / 550));
    @(posedge ref_clk_i);
    src_run <= 1'b0;
    waitv("lost", sync_lost_o, 1'b1, 600, n);
    check("lost late", 16'(n > REF_CLK_KHZ / 550), 16'h0001);
    per_of(p);
    check("slow", 16'(p),
      16'(REF_CLK_KHZ / 550 * SLOW_NUM / SLOW_DEN));
    @(posedge ref_clk_i);
    src_run <= 1'b1;
    waitv("relock", sync_lost_o, 1'b0, 400, n);
  endtask : t_auto_in

  task automatic t_power();
    int n;
    wr(8'h61, 16'h0001);
    @(posedge ref_clk_i);
    en_pin_i <= 1'b1;
    waitv("hs on", hs_drv_en_o, 1'b1, 20, n);
    check("ls on", 16'(ls_drv_en_o), 16'h0001);
    repeat (20000) @(negedge ref_clk_i);
    check("pg rise", 16'(power_good_output_oe_n_o), 16'h0000);
    waitv("pg up", power_good_output_oe_n_o, 1'b1, 8000, n);
    check("ref top", 16'(ref_level_o), 16'h03FF);
    wr(8'h43, 16'h9000);
    waitv("pg uv", power_good_output_oe_n_o, 1'b0, 5, n);
    wr(8'h43, 16'h0000);
    waitv("pg ok", power_good_output_oe_n_o, 1'b1, 5, n);
    wr(8'h61, 16'h0000);
    @(posedge ref_clk_i);
    fault_shutdown_i <= 1'b1;
    waitv("fault pg", power_good_output_oe_n_o, 1'b0, 2, n);
    waitv("fault hs", hs_drv_en_o, 1'b0, 4, n);
    @(posedge ref_clk_i);
    fault_shutdown_i <= 1'b0;
    waitv("pg back", power_good_output_oe_n_o, 1'b1, 60, n);
    wr(8'h01, 16'h0000);
    waitv("cmd off", hs_drv_en_o, 1'b0, 4, n);
    check("no neg", 16'(neg_current_en_o), 16'h0000);
    wr(8'h01, 16'h0080);
    waitv("cmd on", power_good_output_oe_n_o, 1'b1, 60, n);
    wr(8'h02, 16'h0003);
    @(posedge ref_clk_i);
    en_pin_i <= 1'b0;
    waitv("pg stop", power_good_output_oe_n_o, 1'b0, 10, n);
    waitv("neg", neg_current_en_o, 1'b1, 2, n);
    repeat (45000) @(negedge ref_clk_i);
    check("falling", 16'(hs_drv_en_o), 16'h0001);
    waitv("fall end", hs_drv_en_o, 1'b0, 6000, n);
    check("ref zero", 16'(ref_level_o), 16'h0000);
  endtask : t_power

  task automatic t_follow();
    logic [15:0] d;
    @(posedge ref_clk_i);
    ground_sense_follower_pin_i <= 1'b1;
    address_phase_strap_open_i <= 1'b0;
    address_phase_strap_pin_i <= 4'hC;
    do_reset();
    repeat (40) @(negedge ref_clk_i);
    rd(8'hE0, d);
    check("follower", 16'(d[5]), 16'h0001);
    check("stacked", 16'(d[4]), 16'h0001);
    check("follower in", 16'(d[8:7]), 16'h0003);
    check("oe follower", 16'(sync_oe_n_o), 16'h0001);
    rd(8'hE1, d);
    check("adr out", 16'(d[10]), 16'h0001);
  endtask : t_follow

  initial begin
    nrst_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 16'h0000;
    en_pin_i = 1'b0;
    frequency_strap_pin_i = 3'h3;
    stack_strap_pin_i = 4'h0;
    address_phase_strap_pin_i = 4'h0;
    address_phase_strap_open_i = 1'b1;
    ground_sense_follower_pin_i = 1'b0;
    vout_code_i = 16'h8000;
    fault_shutdown_i = 1'b0;
    src_run = 1'b0;
    n_errors = 0;
    compares = 0;
    do_reset();
    t_regs();
    t_auto_out();
    t_auto_in();
    t_power();
    t_follow();
    results();
  end
endmodule : tb
